// [design/frc_read_cmd.sv]
// Floppy read command interpreter: command, execution and result phases.
// Assumes an APB master and a disk side that answers sector requests with a byte stream.
`timescale 1ns/1ps

// What this block does
// - Read commands pass command, execute, result phases; unknown opcodes skip execute
// - Status bytes readable after operation ends
// - Cylinder covers positions 0 to 256
// - Lock keeps queue, precomp settings
// - Skip flag passes deleted-mark sectors
// - Size code sets bytes per sector
// - Execution moves sector data to host
// - Result returns seven bytes in order
// - Programmable precompensation start track held
// - Write gate setting held and passed to the data path
module frc_read_cmd (
	input wire logic pclk, // Bus clock, 100 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire frc_pkg::frc_disk_byte_type disk_in, // Sector byte stream
	output logic disk_in_ready, // Accepting a sector byte
	output frc_pkg::frc_disk_req_type disk_req, // Sector request
	output frc_pkg::frc_config_type config_out, // Settings to the data path
	output logic irq // Level interrupt
);

	// Whole state of the block
	typedef struct packed {
		frc_pkg::frc_phase_type phase; // Current phase
		logic [3:0] cmd_idx; // Command byte counter
		logic [7:0] opcode; // Opcode byte
		logic [7:0] select; // Drive and head byte
		logic [8:0] cyl; // Cylinder
		logic [7:0] head; // Head byte
		logic [7:0] record; // Record number
		logic [7:0] size_code; // Sector size code
		logic [7:0] last_sector_of_track; // Last sector
		logic [7:0] gap_length; // Gap length
		logic [7:0] data_length; // Data length
		logic waiting; // Sector requested, bytes not yet done
		logic [15:0] byte_cnt; // Bytes left in sector
		logic [7:0] data_buf; // Byte held for host
		logic data_full; // Byte held
		logic sector_deleted; // Current sector deleted
		logic [7:0] st0; // Status byte zero
		logic [7:0] st1; // Status byte one
		logic [7:0] st2; // Status byte two
		logic [2:0] res_idx; // Result byte counter
		frc_pkg::frc_config_type cfg; // Settings
		logic [2:0] irq_stat; // Sticky events
		logic [2:0] irq_en; // Event enables
		logic [31:0] prdata; // Read data
		logic pready; // Ready
		logic pslverr; // Error
		frc_pkg::frc_disk_req_type req; // Request
		logic in_ready; // Stream ready
		logic irq; // Interrupt
	} frc_state_type;

	// Present and next state
	frc_state_type cur;
	frc_state_type next_cur;

	logic setup; // Setup cycle of an APB transfer
	logic wr_cmd; // Command byte written
	logic rd_res; // Result byte read
	logic rd_dat; // Data byte read
	logic take_byte; // Stream byte accepted
	logic [2:0] ev; // Events this cycle
	logic [7:0] res_byte; // Result byte selected
	logic [15:0] sec_len; // Sector length from size code
	logic is_read; // Valid read opcode

	// Every access is decoded in its setup cycle, so side effects happen once
	assign setup = psel && !penable;
	// Command byte strobe
	assign wr_cmd = setup && pwrite && paddr == frc_pkg::OFF_CMD;
	// Result read advances the result pointer
	assign rd_res = setup && !pwrite && paddr == frc_pkg::OFF_RESULT;
	// Data read frees the holding stage
	assign rd_dat = setup && !pwrite && paddr == frc_pkg::OFF_DATA;
	// Stream handshake with the disk side
	assign take_byte = cur.in_ready && disk_in.valid;

	// size code length
	// Data length only applies to size code zero, as on classic parts
	assign sec_len = (cur.size_code == 8'h00) ? {8'h00, cur.data_length}
		: (16'h0080 << cur.size_code[2:0]);
	assign is_read = cur.opcode[4:0] == frc_pkg::OPC_READ
		|| cur.opcode[4:0] == frc_pkg::OPC_READ_DEL;

	always_comb begin
		unique case (cur.res_idx)
			3'h0: res_byte = cur.st0;
			3'h1: res_byte = cur.st1;
			3'h2: res_byte = cur.st2;
			3'h3: res_byte = cur.cyl[7:0];
			3'h4: res_byte = cur.head;
			3'h5: res_byte = cur.record;
			// Seventh byte: size code
			default: res_byte = cur.size_code;
		endcase
	end

	// Next state of the whole block
	always_comb begin
		next_cur = cur;
		ev = 3'h0;
		// Bus answer and request strobes last one cycle
		next_cur.pready = 1'b0;
		next_cur.pslverr = 1'b0;
		next_cur.req.start = 1'b0;
		// APB answers one cycle after setup
		if (setup) begin
			next_cur.pready = 1'b1;
			// Read data is zero unless a register below fills it
			next_cur.prdata = 32'h0000_0000;
		end
		// Register reads
		if (setup && !pwrite) begin
			unique case (paddr)
				frc_pkg::OFF_RESULT: next_cur.prdata = {24'h0, res_byte};
				frc_pkg::OFF_STATUS: next_cur.prdata = {26'h0, cur.data_full,
					cur.waiting, 2'h0, cur.phase};
				frc_pkg::OFF_DATA: next_cur.prdata = {24'h0, cur.data_buf};
				frc_pkg::OFF_CONFIG: next_cur.prdata = {17'h0, cur.cfg};
				frc_pkg::OFF_IRQ_STAT: next_cur.prdata = {29'h0, cur.irq_stat};
				frc_pkg::OFF_IRQ_EN: next_cur.prdata = {29'h0, cur.irq_en};
				// Write-only registers read back as zero
				frc_pkg::OFF_CMD, frc_pkg::OFF_SOFTRST, frc_pkg::OFF_IRQ_CLR: ;
				// Unmapped or misaligned address
				default: next_cur.pslverr = 1'b1;
			endcase
		end
		// Register writes other than command bytes
		if (setup && pwrite) begin
			unique case (paddr)
				frc_pkg::OFF_CONFIG: next_cur.cfg = pwdata[14:0];
				frc_pkg::OFF_IRQ_CLR: next_cur.irq_stat = cur.irq_stat & ~pwdata[2:0];
				frc_pkg::OFF_IRQ_EN: next_cur.irq_en = pwdata[2:0];
				frc_pkg::OFF_SOFTRST: begin
					// Soft reset abandons the command in flight
					next_cur.phase = frc_pkg::PH_COMMAND;
					next_cur.cmd_idx = 4'h0;
					next_cur.waiting = 1'b0;
					next_cur.data_full = 1'b0;
					next_cur.in_ready = 1'b0;
					if (!cur.cfg.lock) begin
						next_cur.cfg.queue_enable_setting = 1'b0;
						next_cur.cfg.queue_threshold_setting = frc_pkg::CFG_DEFAULT_THR[3:0];
						next_cur.cfg.precomp_start_track = frc_pkg::CFG_DEFAULT_PRECOMP_START_TRACK;
					end
				end
				// Command bytes are handled by the phase logic below
				frc_pkg::OFF_CMD: ;
				// Writes to read-only registers are dropped without an error
				frc_pkg::OFF_RESULT, frc_pkg::OFF_STATUS, frc_pkg::OFF_DATA: ;
				frc_pkg::OFF_IRQ_STAT: ;
				// Unmapped or misaligned address
				default: next_cur.pslverr = 1'b1;
			endcase
		end
		// Host drains the held byte in any phase; the last byte of a
		// command is read after the result phase has begun, so clearing
		// only during execution would stall the next command for good
		if (rd_dat) begin
			next_cur.data_full = 1'b0;
		end
		unique case (cur.phase)
			frc_pkg::PH_COMMAND: begin
				if (wr_cmd) begin
					unique case (cur.cmd_idx)
						// Opcode with its multitrack, density and skip flags
						4'h0: next_cur.opcode = pwdata[7:0];
						4'h1: next_cur.select = pwdata[7:0];
						4'h2: next_cur.cyl = {1'b0, pwdata[7:0]};
						// Head, record and size kept as written
						4'h3: next_cur.head = pwdata[7:0];
						4'h4: next_cur.record = pwdata[7:0];
						4'h5: next_cur.size_code = pwdata[7:0];
						4'h6: next_cur.last_sector_of_track = pwdata[7:0];
						4'h7: next_cur.gap_length = pwdata[7:0];
						// Ninth byte: data length, used when size code is zero
						default: next_cur.data_length = pwdata[7:0];
					endcase
					next_cur.cmd_idx = cur.cmd_idx + 4'h1;
					// Unknown opcode goes straight to the seven-byte result phase
					if (cur.cmd_idx == 4'h0 && pwdata[4:0] != frc_pkg::OPC_READ
						&& pwdata[4:0] != frc_pkg::OPC_READ_DEL) begin
						next_cur.st0 = frc_pkg::ST0_INVALID;
						next_cur.st1 = 8'h00;
						next_cur.st2 = 8'h00;
						next_cur.res_idx = 3'h0;
						next_cur.phase = frc_pkg::PH_RESULT;
						ev[0] = 1'b1;
					end
				end
				// All nine bytes in: start execution
				if (cur.cmd_idx == frc_pkg::CMD_BYTES && is_read) begin
					next_cur.phase = frc_pkg::PH_EXECUTE;
					// A byte left over from an abandoned command must not block the stream
					next_cur.data_full = 1'b0;
					next_cur.st0 = {5'h00, cur.select[frc_pkg::BIT_HEAD], cur.select[1:0]};
					next_cur.st1 = 8'h00;
					next_cur.st2 = 8'h00;
					next_cur.cmd_idx = 4'h0;
				end
			end
			frc_pkg::PH_EXECUTE: begin
				if (!cur.waiting) begin
					next_cur.req.start = 1'b1;
					next_cur.req.drive = cur.select[1:0];
					next_cur.req.head = cur.select[frc_pkg::BIT_HEAD];
					next_cur.req.cylinder = cur.cyl;
					next_cur.req.record = cur.record;
					next_cur.req.size_code = cur.size_code;
					next_cur.req.double_density = cur.opcode[frc_pkg::BIT_DD];
					// Wait for the sector, counting its expected length
					next_cur.waiting = 1'b1;
					next_cur.in_ready = 1'b1;
					next_cur.byte_cnt = sec_len;
					next_cur.sector_deleted = 1'b0;
				end else begin
					// Stream byte accepted while the holding stage is empty
					if (take_byte) begin
						next_cur.sector_deleted = disk_in.deleted;
						if (!(cur.opcode[frc_pkg::BIT_SK] && disk_in.deleted)
							&& cur.byte_cnt != 16'h0000) begin
							next_cur.data_buf = disk_in.data;
							next_cur.data_full = 1'b1;
							next_cur.byte_cnt = cur.byte_cnt - 16'h0001;
							ev[1] = 1'b1;
						end
						// Deleted mark is reported even when its bytes are skipped
						if (disk_in.deleted) begin
							next_cur.st2 = cur.st2 | frc_pkg::ST2_CTRL_MARK;
						end
						// One byte per handshake; ready returns once the stage drains
						next_cur.in_ready = 1'b0;
					end else if (cur.waiting && !cur.in_ready && !next_cur.data_full) begin
						// Stage empty again: take the next byte, skipped ones too,
						// so a deleted sector still runs on to its last byte
						next_cur.in_ready = 1'b1;
					end
					// Sector end: advance record, head or finish
					if (take_byte && disk_in.last) begin
						next_cur.waiting = 1'b0;
						next_cur.in_ready = 1'b0;
						if (cur.record == cur.last_sector_of_track) begin
							if (cur.opcode[frc_pkg::BIT_MT] && !cur.select[frc_pkg::BIT_HEAD]) begin
								next_cur.select[frc_pkg::BIT_HEAD] = 1'b1;
								next_cur.head = 8'h01;
								next_cur.record = 8'h01;
							end else begin
								// No further head: step the cylinder and close with end status
								next_cur.record = 8'h01;
								next_cur.head = {7'h00, cur.opcode[frc_pkg::BIT_MT] ? 1'b0 : cur.head[0]};
								// Cylinder saturates at the top of its range
								if (cur.cyl != frc_pkg::CYL_MAX) begin
									next_cur.cyl = cur.cyl + 9'h001;
								end
								next_cur.st0 = cur.st0 | frc_pkg::ST0_ABNORMAL;
								next_cur.st1 = frc_pkg::ST1_END_CYL;
								next_cur.res_idx = 3'h0;
								next_cur.phase = frc_pkg::PH_RESULT;
								ev[0] = 1'b1;
							end
						end else begin
							// Next record on the same track
							next_cur.record = cur.record + 8'h01;
						end
					end
				end
			end
			frc_pkg::PH_RESULT: begin
				if (rd_res) begin
					// Seventh read returns to the command phase
					if (cur.res_idx == frc_pkg::RES_BYTES - 3'h1) begin
						next_cur.phase = frc_pkg::PH_COMMAND;
						next_cur.cmd_idx = 4'h0;
						ev[2] = 1'b1;
					end else begin
						next_cur.res_idx = cur.res_idx + 3'h1;
					end
				end
			end
			// Unused phase code: return to a clean command phase
			default: begin
				next_cur.phase = frc_pkg::PH_COMMAND;
				next_cur.cmd_idx = 4'h0;
			end
		endcase
		// Sticky events, set wins over clear
		next_cur.irq_stat = next_cur.irq_stat | ev;
		// Stream stalls while a byte is held for the host
		next_cur.in_ready = next_cur.in_ready && !next_cur.data_full;
		// Level interrupt, registered so the pin comes from a flip-flop
		next_cur.irq = |(next_cur.irq_stat & next_cur.irq_en);
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Settings return to zero too; only soft reset honours the lock
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// Outputs taken straight from the state register
	assign prdata = cur.prdata;
	assign pready = cur.pready;
	assign pslverr = cur.pslverr;
	assign disk_req = cur.req;
	assign disk_in_ready = cur.in_ready;
	assign config_out = cur.cfg;
	assign irq = cur.irq;

endmodule : frc_read_cmd

// [design/frc_pkg.sv]
// Package for the floppy read command protocol block.
// Assumes an APB master and a disk side that streams sector bytes with valid/ready.
package frc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CMD = 8'h00; // Command byte write
	localparam logic [7:0] OFF_RESULT = 8'h04; // Result byte read
	localparam logic [7:0] OFF_STATUS = 8'h08; // Phase and flags
	localparam logic [7:0] OFF_DATA = 8'h0C; // Sector data read
	localparam logic [7:0] OFF_CONFIG = 8'h10; // Lock, queue, precomp, write gate
	localparam logic [7:0] OFF_SOFTRST = 8'h14; // Software reset strobe
	localparam logic [7:0] OFF_IRQ_STAT = 8'h18; // Sticky event bits
	localparam logic [7:0] OFF_IRQ_CLR = 8'h1C; // Write one to clear
	localparam logic [7:0] OFF_IRQ_EN = 8'h20; // Interrupt enable
	// Opcode fields
	localparam logic [4:0] OPC_READ = 5'h06; // Read sector, bits 4..0
	localparam logic [4:0] OPC_READ_DEL = 5'h0C; // Read deleted sector
	localparam int BIT_MT = 7; // Multitrack flag position
	localparam int BIT_DD = 6; // Double-density position
	localparam int BIT_SK = 5; // Skip flag position
	localparam int BIT_HEAD = 2; // Head select position
	// Sequence lengths
	localparam logic [3:0] CMD_BYTES = 4'h9; // Command phase byte count
	localparam logic [2:0] RES_BYTES = 3'h7; // Result phase byte count
	// Defaults after reset
	localparam logic [7:0] CFG_DEFAULT_THR = 8'h00; // Queue threshold default
	localparam logic [7:0] CFG_DEFAULT_PRECOMP_START_TRACK = 8'h00; // Precomp track default
	localparam logic [8:0] CYL_MAX = 9'h100; // Highest cylinder, 256
	// Status bits in the three status bytes
	localparam logic [7:0] ST0_ABNORMAL = 8'h40; // Abnormal termination
	localparam logic [7:0] ST0_INVALID = 8'h80; // Invalid command
	localparam logic [7:0] ST1_END_CYL = 8'h80; // Ran past the last sector
	localparam logic [7:0] ST2_CTRL_MARK = 8'h40; // Deleted mark seen

	typedef enum logic [1:0] {PH_COMMAND, PH_EXECUTE, PH_RESULT} frc_phase_type;

	// Sector byte arriving from the disk side
	typedef struct packed {
		logic valid; // Byte present
		logic [7:0] data; // Byte value
		logic deleted; // Sector carries deleted-data mark
		logic last; // Last byte of the sector
	} frc_disk_byte_type;

	// Sector request toward the disk side
	typedef struct packed {
		logic start; // One-cycle request pulse
		logic [1:0] drive; // Drive number
		logic head; // Head
		logic [8:0] cylinder; // Cylinder 0..256
		logic [7:0] record; // Sector number
		logic [7:0] size_code; // Sector size code
		logic double_density; // Encoding
	} frc_disk_req_type;

	// Settings kept across software reset when locked
	typedef struct packed {
		logic lock; // Keep settings through soft reset
		logic queue_enable_setting; // Queue enable
		logic [3:0] queue_threshold_setting; // Queue threshold
		logic [7:0] precomp_start_track; // Precomp start track
		logic write_gate_timing; // Write-enable timing select
	} frc_config_type;
endpackage : frc_pkg

// [tb/frc_assertions.sv]
// Port checker for the read command block.
// Bound to each frc_read_cmd; sees only its ports.
`timescale 1ns/1ps
module frc_assertions (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // Select
	input wire logic penable, // Access phase
	input wire logic pwrite, // Direction
	input wire logic [7:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire frc_pkg::frc_disk_byte_type disk_in, // Byte in
	input wire logic disk_in_ready, // Byte taken
	input wire frc_pkg::frc_disk_req_type disk_req, // Request
	input wire frc_pkg::frc_config_type config_out, // Settings
	input wire logic irq // Interrupt
);
	logic setup; // Setup cycle
	logic cw; // Settings write or soft reset
	assign setup = psel && !penable;
	assign cw = setup && pwrite
		&& (paddr == frc_pkg::OFF_CONFIG || paddr == frc_pkg::OFF_SOFTRST);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_ANSWER: assert property (setup |=> pready)
		else $error("no ready after setup");
	AST_PULSE: assert property (pready |=> !pready)
		else $error("ready too long");
	AST_ERR_MAP: assert property (setup && paddr > 8'h20 |=> pslverr)
		else $error("no error on unmapped");
	AST_OK_MAP: assert property (setup && paddr <= 8'h20 && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("error on mapped");
	AST_ERR_RDY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_START: assert property (disk_req.start |=> !disk_req.start)
		else $error("start not a pulse");
	AST_HOLD: assert property (disk_in.valid && disk_in_ready && !disk_in.deleted |=> !disk_in_ready)
		else $error("no stall on held byte");
	AST_CFG: assert property (!$stable(config_out) |-> $past(cw, 1) || $past(cw, 2))
		else $error("settings changed alone");
endmodule : frc_assertions

bind frc_read_cmd frc_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .disk_in(disk_in), .disk_in_ready(disk_in_ready),
	.disk_req(disk_req), .config_out(config_out), .irq(irq));

// [tb/frc_disk_model.sv]
// Disk side model: one sector per request, byte i xor record.
// Assumes the block raises ready when it can take a byte.
`timescale 1ns/1ps
module frc_disk_model (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire frc_pkg::frc_disk_req_type disk_req, // Request
	input wire logic disk_in_ready, // Block takes byte
	input wire logic del, // Deleted mark on sectors
	input wire logic slow, // Pause after each byte
	input wire logic [7:0] len, // Bytes per sector
	output frc_pkg::frc_disk_byte_type disk_in // Byte stream
);
	logic busy; // Sector in flight
	logic gap; // Pause cycle
	logic [7:0] cnt; // Byte index
	logic [7:0] rec; // Record of request
	logic [7:0] junk; // Idle data, never stale
	always_comb begin
		disk_in.valid = busy && !gap;
		disk_in.data = disk_in.valid ? cnt ^ rec : junk;
		disk_in.deleted = del;
		disk_in.last = cnt == len - 8'h01;
	end
	// Counts bytes, idles with toggling data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b0;
			gap <= 1'b0;
			cnt <= 8'h00;
			rec <= 8'h00;
			junk <= 8'h5A;
		end else begin
			junk <= ~junk;
			gap <= slow && disk_in.valid && disk_in_ready;
			if (disk_req.start) begin
				busy <= 1'b1;
				cnt <= 8'h00;
				rec <= disk_req.record;
			end else if (disk_in.valid && disk_in_ready) begin
				cnt <= cnt + 8'h01;
				busy <= !disk_in.last;
			end
		end
	end
endmodule : frc_disk_model

// [tb/frc_read_cmd_tb_top.sv]
// Bench for the read command block: APB host, disk model, queued checks.
// Assumes the disk model answers every sector request.
`timescale 1ns/1ps
module frc_read_cmd_tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, v;
	logic pready, pslverr, irq, disk_in_ready, del = 0, slow = 0;
	frc_pkg::frc_disk_byte_type disk_in;
	frc_pkg::frc_disk_req_type disk_req;
	frc_pkg::frc_config_type config_out;
	int err_total = 0, n_tests = 0, cyc = 0, seed = 49212;
	logic [64:0] rq[$]; // Read notes: error, mask, value
	logic [20:0] dq[$]; // Request notes: density, drive, head, cylinder, record
	logic [64:0] e;
	initial forever #5 pclk = ~pclk;
	frc_read_cmd i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .disk_in(disk_in), .disk_in_ready(disk_in_ready),
		.disk_req(disk_req), .config_out(config_out), .irq(irq));
	frc_disk_model i_disk (.pclk(pclk), .presetn(presetn), .disk_req(disk_req),
		.disk_in_ready(disk_in_ready), .del(del), .slow(slow), .len(8'h04), .disk_in(disk_in));
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task wrap_up();
		$display("counts: %0d compared, %0d wrong", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	// Holds the request until ready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [64:0] n);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) rq.push_back(n);
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task rdx(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
		apb(1'b0, a, 32'h0, {1'b0, m, x});
	endtask : rdx
	task cmd(input logic [71:0] b);
		for (int i = 8; i >= 0; i--) apb(1'b1, frc_pkg::OFF_CMD, {24'h0, b[8*i+:8]}, 65'h0);
	endtask : cmd
	task res(input logic [55:0] x, input logic [55:0] m);
		for (int i = 6; i >= 0; i--) rdx(frc_pkg::OFF_RESULT, x[8*i+:8], m[8*i+:8]);
	endtask : res
	// Polls for a held byte, then takes it
	task sec(input logic [7:0] r);
		for (int i = 0; i < 4; i++) begin
			rd = 32'h0;
			for (int k = 0; k < 50 && rd[5] !== 1'b1; k++) rdx(frc_pkg::OFF_STATUS, 0, 0);
			rdx(frc_pkg::OFF_DATA, {24'h0, i[7:0] ^ r}, 32'hFF);
		end
	endtask : sec
	task wph();
		rd = 32'h0;
		for (int k = 0; k < 50 && rd[1:0] !== 2'h2; k++) rdx(frc_pkg::OFF_STATUS, 0, 0);
	endtask : wph
	// Compares each read and request against its note; cuts a hang short
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 20000) begin
			err_total++;
			wrap_up();
		end else begin
			if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
				e = rq.pop_front();
				cmp({31'h0, pslverr}, {31'h0, e[64]});
				cmp(prdata & e[63:32], e[31:0] & e[63:32]);
			end
			if (disk_req.start === 1'b1)
				cmp({disk_req.double_density, disk_req.drive, disk_req.head,
					disk_req.cylinder, disk_req.record},
					dq.size() > 0 ? dq.pop_front() : 21'h1FFFFF);
		end
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		apb(1'b1, frc_pkg::OFF_IRQ_EN, 32'h1, 65'h0);
		rdx(frc_pkg::OFF_IRQ_EN, 32'h1, 32'h7);
		// Plain read, drive 2 head 1, ends at track end
		dq.push_back({1'b0, 2'h2, 1'b1, 9'h020, 8'h03});
		cmd(72'h06_06_20_01_03_00_03_1B_04);
		rdx(frc_pkg::OFF_STATUS, 32'h1, 32'h3);
		sec(8'h03);
		repeat (2) @(posedge pclk);
		cmp({31'h0, irq}, 32'h1);
		res(56'h40_80_00_21_01_01_00, 56'hC0_FF_40_FF_FF_FF_FF);
		rdx(frc_pkg::OFF_STATUS, 32'h0, 32'h3);
		apb(1'b1, frc_pkg::OFF_IRQ_CLR, 32'h7, 65'h0);
		repeat (2) @(posedge pclk);
		cmp({31'h0, irq}, 32'h0);
		$display("test plain read done");
		// Multitrack read deleted, double density, slow disk, both heads
		slow <= 1;
		dq.push_back({1'b1, 2'h1, 1'b0, 9'h005, 8'h01});
		dq.push_back({1'b1, 2'h1, 1'b1, 9'h005, 8'h01});
		cmd(72'hCC_01_05_00_01_00_01_1B_04);
		sec(8'h01);
		cmp({31'h0, irq}, 32'h0);
		sec(8'h01);
		wph();
		res(56'h40_80_00_06_00_01_00, 56'hC0_FF_00_FF_FF_FF_FF);
		$display("test multitrack done");
		// Skip flag passes a deleted sector
		slow <= 0;
		del <= 1;
		dq.push_back({1'b0, 2'h0, 1'b0, 9'h007, 8'h02});
		cmd(72'h26_00_07_00_02_00_02_1B_04);
		wph();
		res(56'h40_80_40_08_00_01_00, 56'hC0_FF_40_FF_FF_FF_FF);
		$display("test skip done");
		// Unknown opcode goes straight to results
		apb(1'b1, frc_pkg::OFF_CMD, 32'h1F, 65'h0);
		wph();
		res(56'h80_00_00_00_00_00_00, 56'hFF_00_00_00_00_00_00);
		$display("test bad opcode done");
		// Settings, soft reset unlocked then locked
		v = ($random(seed) & 32'h3FFF) | 32'h1;
		apb(1'b1, frc_pkg::OFF_CONFIG, v, 65'h0);
		rdx(frc_pkg::OFF_CONFIG, v, 32'h7FFF);
		cmp({17'h0, config_out}, v);
		apb(1'b1, frc_pkg::OFF_SOFTRST, 32'h0, 65'h0);
		repeat (2) @(posedge pclk);
		cmp({17'h0, config_out}, v & 32'h4001);
		v = v | 32'h4000;
		apb(1'b1, frc_pkg::OFF_CONFIG, v, 65'h0);
		apb(1'b1, frc_pkg::OFF_SOFTRST, 32'h0, 65'h0);
		repeat (2) @(posedge pclk);
		cmp({17'h0, config_out}, v);
		apb(1'b0, 8'h40, 32'h0, {1'b1, 64'h0});
		$display("test settings done");
		wrap_up();
	end
endmodule : frc_read_cmd_tb_top
